// >>> acpm_pkg.sv
// Purpose: shared constants and types of the power-mode controller
// Assumes: registers sit at byte addresses on the serial register port
// Notes:   one clock at 250 MHz; all rates derive from the 3200 Hz grid
package acpm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int ODR_TOP_HZ = 3200;
  // cycles of one 3200 Hz step, the finest internal sample grid
  localparam int BASE_CYCLES = CLK_HZ / ODR_TOP_HZ;
  // rate codes span fifteen halvings below the top rate
  localparam int SUB_W = 15;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INACT_THRESH = 8'h25;
  localparam logic [7:0] ADDR_INACT_TIME = 8'h26;
  localparam logic [7:0] ADDR_RATE = 8'h2C;
  localparam logic [7:0] ADDR_POWER = 8'h2D;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MEASURE_BIT = 3;
  localparam int AUTOSLEEP_BIT = 4;
  localparam int LINK_BIT = 5;
  localparam int LOW_POWER_BIT = 4;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 4;

  // ---------------------------------------------------------------
  // rate codes and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RATE_CODE_TOP = 4'hF;
  // 6.25 Hz, the fastest code below 8 Hz
  localparam logic [3:0] RATE_CODE_SLEEP = 4'h6;
  localparam logic [7:0] RST_INACT_THRESH = 8'h00;
  localparam logic [7:0] RST_INACT_TIME = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h0A;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // power modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACPM_STANDBY = 2'b00,
    ACPM_MEASURE = 2'b01,
    ACPM_SLEEP = 2'b10
  } acpm_mode_t;

endpackage

// >>> acpm_rate_div.sv
// Purpose: 3200 Hz grid tick and rate-code sample tick
// Assumes: reset already synchronised by the caller
// Notes:   grid runs always; sample tick only while run is high
`timescale 1ns/1ps
module acpm_rate_div #(
  parameter int unsigned BASE_CYCLES = acpm_pkg::BASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [3:0] rate_code,
  output logic base_tick,
  output logic sample_tick
);

  // ---------------------------------------------------------------
  // prescaler and decimation counter
  // ---------------------------------------------------------------
  logic [31:0] pre_cnt;
  logic [31:0] next_pre_cnt;
  logic [acpm_pkg::SUB_W-1:0] sub_cnt;
  logic [acpm_pkg::SUB_W-1:0] next_sub_cnt;
  logic [acpm_pkg::SUB_W-1:0] mask;
  logic next_base_tick;
  logic next_sample_tick;
  logic wrap;

  // each code step down halves the rate: one more low bit in the mask,
  // so the top code needs no decimation at all
  always_comb begin
    mask = ~({acpm_pkg::SUB_W{1'b1}} <<
      (acpm_pkg::RATE_CODE_TOP - rate_code));
    wrap = (pre_cnt == 32'(BASE_CYCLES - 1));
    next_pre_cnt = wrap ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
    next_base_tick = wrap;
    // counter restarts in standby so the first sample is a full period
    if (!run) begin
      next_sub_cnt = '0;
    end else if (wrap) begin
      next_sub_cnt = sub_cnt + 1'b1;
    end else begin
      next_sub_cnt = sub_cnt;
    end
    next_sample_tick = run && wrap && ((sub_cnt & mask) == mask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 32'h0000_0000;
      sub_cnt <= '0;
      base_tick <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      sub_cnt <= next_sub_cnt;
      base_tick <= next_base_tick;
      sample_tick <= next_sample_tick;
    end
  end

endmodule

// >>> acpm_power_ctrl.sv
// Purpose: standby / measurement / autosleep mode control and rate select
// Assumes: register port and detector pulses come from core_clk logic
// Notes:   mode changes land only on the 3200 Hz grid tick
`timescale 1ns/1ps
module acpm_power_ctrl #(
  parameter int unsigned BASE_CYCLES = acpm_pkg::BASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic act_detect,
  input wire logic inact_detect,
  output logic [7:0] inactivity_threshold,
  output logic [7:0] inactivity_time,
  output logic [1:0] power_mode,
  output logic sensing_en,
  output logic sample_tick,
  output logic conv_tick,
  output logic low_power_active,
  output logic [3:0] odr_code,
  output logic fifo_hold
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // assertion is immediate, release waits two edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] rate_and_power_select;
  logic [7:0] power_control;
  logic [7:0] next_inact_thresh;
  logic [7:0] next_inact_time;
  logic [7:0] next_rate;
  logic [7:0] next_power;
  logic [7:0] next_rdata;

  // writes are taken in every mode, so setup can happen in standby
  always_comb begin
    next_inact_thresh = inactivity_threshold;
    next_inact_time = inactivity_time;
    next_rate = rate_and_power_select;
    next_power = power_control;
    next_rdata = reg_rdata;
    if (reg_wr) begin
      case (reg_addr)
        acpm_pkg::ADDR_INACT_THRESH: next_inact_thresh = reg_wdata;
        acpm_pkg::ADDR_INACT_TIME: next_inact_time = reg_wdata;
        acpm_pkg::ADDR_RATE: next_rate = reg_wdata;
        acpm_pkg::ADDR_POWER: next_power = reg_wdata;
        default: next_rate = rate_and_power_select;
      endcase
    end
    // unmapped addresses read as zero
    if (reg_rd) begin
      case (reg_addr)
        acpm_pkg::ADDR_INACT_THRESH: next_rdata = inactivity_threshold;
        acpm_pkg::ADDR_INACT_TIME: next_rdata = inactivity_time;
        acpm_pkg::ADDR_RATE: next_rdata = rate_and_power_select;
        acpm_pkg::ADDR_POWER: next_rdata = power_control;
        default: next_rdata = acpm_pkg::READ_ZERO;
      endcase
    end
  end

  // mode transitions never touch these, only the register port does
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inactivity_threshold <= acpm_pkg::RST_INACT_THRESH;
      inactivity_time <= acpm_pkg::RST_INACT_TIME;
      rate_and_power_select <= acpm_pkg::RST_RATE;
      power_control <= acpm_pkg::RST_POWER;
      reg_rdata <= acpm_pkg::READ_ZERO;
    end else begin
      inactivity_threshold <= next_inact_thresh;
      inactivity_time <= next_inact_time;
      rate_and_power_select <= next_rate;
      power_control <= next_power;
      reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  logic measure_req;
  logic sleep_armed;
  logic lp_req;
  logic [3:0] rate_req;

  assign measure_req = power_control[acpm_pkg::MEASURE_BIT];
  // both bits are needed, as the host is told to set them together
  assign sleep_armed = power_control[acpm_pkg::AUTOSLEEP_BIT] &&
    power_control[acpm_pkg::LINK_BIT];
  assign lp_req = rate_and_power_select[acpm_pkg::LOW_POWER_BIT];
  assign rate_req =
    rate_and_power_select[acpm_pkg::RATE_LSB +: acpm_pkg::RATE_W];

  // ---------------------------------------------------------------
  // rate generation
  // ---------------------------------------------------------------
  acpm_pkg::acpm_mode_t mode;
  acpm_pkg::acpm_mode_t next_mode;
  logic base_tick;
  logic running;
  logic [3:0] eff_code;

  assign running = (mode != acpm_pkg::ACPM_STANDBY);
  // sleep caps the rate at 6.25 Hz, slower codes are kept as asked
  assign eff_code = (mode == acpm_pkg::ACPM_SLEEP &&
    rate_req > acpm_pkg::RATE_CODE_SLEEP) ?
    acpm_pkg::RATE_CODE_SLEEP : rate_req;

  acpm_rate_div #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(running),
    .rate_code(eff_code),
    .base_tick(base_tick),
    .sample_tick(sample_tick)
  );

  // ---------------------------------------------------------------
  // detector event capture
  // ---------------------------------------------------------------
  logic inact_pend;
  logic act_pend;
  logic next_inact_pend;
  logic next_act_pend;

  // pulses wait for the grid tick; a pulse on that tick is kept
  always_comb begin
    next_inact_pend = inact_detect || (inact_pend && !base_tick);
    next_act_pend = act_detect || (act_pend && !base_tick);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inact_pend <= 1'b0;
      act_pend <= 1'b0;
    end else begin
      inact_pend <= next_inact_pend;
      act_pend <= next_act_pend;
    end
  end

  // ---------------------------------------------------------------
  // mode state machine
  // ---------------------------------------------------------------
  // decisions only on the grid tick so no sample is cut in half
  always_comb begin
    next_mode = mode;
    if (base_tick) begin
      case (mode)
        acpm_pkg::ACPM_STANDBY: begin
          if (measure_req) begin
            next_mode = acpm_pkg::ACPM_MEASURE;
          end
        end
        acpm_pkg::ACPM_MEASURE: begin
          if (!measure_req) begin
            next_mode = acpm_pkg::ACPM_STANDBY;
          end else if (sleep_armed && inact_pend) begin
            next_mode = acpm_pkg::ACPM_SLEEP;
          end
        end
        acpm_pkg::ACPM_SLEEP: begin
          if (!measure_req) begin
            next_mode = acpm_pkg::ACPM_STANDBY;
          end else if (act_pend || !sleep_armed) begin
            next_mode = acpm_pkg::ACPM_MEASURE;
          end
        end
        default: next_mode = acpm_pkg::ACPM_STANDBY;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= acpm_pkg::ACPM_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign power_mode = mode;
  assign odr_code = eff_code;
  assign sensing_en = running;
  // standby freezes the FIFO and never clears it
  assign fifo_hold = !running;
  assign low_power_active = running && lp_req;
  // low power converts once per output sample instead of on every step
  assign conv_tick = running &&
    (low_power_active ? sample_tick : base_tick);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_start_cmd;
    mode == acpm_pkg::ACPM_STANDBY && measure_req && base_tick;
  endsequence

  sequence s_quiet_armed;
    mode == acpm_pkg::ACPM_MEASURE && measure_req && sleep_armed &&
      inact_pend && base_tick;
  endsequence

  standby_quiet_a: assert property (mode == acpm_pkg::ACPM_STANDBY |->
    !sample_tick && !conv_tick && !sensing_en)
    else $error("sampling seen in standby");
  measure_entry_a: assert property (s_start_cmd |=>
    mode == acpm_pkg::ACPM_MEASURE && sensing_en)
    else $error("measure command not honoured");
  standby_return_a: assert property (
    mode != acpm_pkg::ACPM_STANDBY && !measure_req && base_tick |=>
    mode == acpm_pkg::ACPM_STANDBY && fifo_hold)
    else $error("standby not reentered");
  mode_boundary_a: assert property ($changed(mode) |->
    $past(base_tick))
    else $error("mode changed off the grid tick");
  reg_write_a: assert property (
    reg_wr && reg_addr == acpm_pkg::ADDR_RATE |=>
    rate_and_power_select == $past(reg_wdata))
    else $error("rate register write lost");
  sleep_entry_a: assert property (s_quiet_armed |=>
    mode == acpm_pkg::ACPM_SLEEP)
    else $error("autosleep not entered");
  sleep_rate_a: assert property (mode == acpm_pkg::ACPM_SLEEP |->
    odr_code <= acpm_pkg::RATE_CODE_SLEEP)
    else $error("sleep rate at or above 8 Hz");
  low_power_a: assert property (
    reg_wr && reg_addr == acpm_pkg::ADDR_RATE &&
    reg_wdata[acpm_pkg::LOW_POWER_BIT] |=> low_power_active == running)
    else $error("low power bit ignored");
  lp_conv_a: assert property (low_power_active && conv_tick |->
    sample_tick)
    else $error("low power converts too often");
  tick_grid_a: assert property (sample_tick |-> base_tick)
    else $error("sample tick off the rate grid");

endmodule

// >>> acpm_host_model.sv
// Purpose: host processor model that drives the register port
// Assumes: port strobes are taken on the rising edge of core_clk
// Notes:   drives only on falling edges; idle lines show inverted data
`timescale 1ns/1ps
module acpm_host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ---------------------------------------------------------------
  // idle state
  // ---------------------------------------------------------------
  // start idle with neutral lines so no access is seen before reset ends
  initial begin
    reg_addr = 8'hFF;
    reg_wdata = 8'hFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // one-cycle write strobe; lines inverted after so stale data never helps
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // read data is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // low power is only asked for where it pays off
  task automatic set_rate(input logic [3:0] code, input logic lp);
    logic use_lp;
    use_lp = lp && (code >= 4'h7) && (code <= 4'hC);
    wr(acpm_pkg::ADDR_RATE, {3'h0, use_lp, code});
  endtask

  // thresholds first, then autosleep and link together with measure
  task automatic arm_autosleep(input logic [7:0] th, input logic [7:0] tm);
    wr(acpm_pkg::ADDR_INACT_THRESH, th);
    wr(acpm_pkg::ADDR_INACT_TIME, tm);
    wr(acpm_pkg::ADDR_POWER, 8'h38);
  endtask
endmodule

// >>> accel_power_mode_control_tb_top.sv
// Purpose: self-checking bench for the power-mode controller
// Assumes: grid step shortened to 8 cycles so rate checks stay short
// Notes:   inputs change on falling edges; outputs sampled there too
`timescale 1ns/1ps
module accel_power_mode_control_tb_top;
  localparam int unsigned BASE = 8;
  logic core_clk, nrst, act_detect, inact_detect, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, th, tm, rv;
  logic [1:0] power_mode;
  logic sensing_en, sample_tick, conv_tick, low_power_active, fifo_hold;
  logic [3:0] odr_code;
  logic [15:0] p, ns, nc, nd;
  int fail_count, n_compared, cycles;
  logic [7:0] adr [4] = '{8'h25, 8'h26, 8'h2C, 8'h2D};
  logic [7:0] rst [4] = '{8'h00, 8'h00, 8'h0A, 8'h00};
  logic [7:0] val [4] = '{8'h5A, 8'hA5, 8'h0F, 8'h00};

  // ---------------------------------------------------------------
  // clock, parts and timeout
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  acpm_host_model host (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  acpm_power_ctrl #(.BASE_CYCLES(BASE)) uut (.core_clk(core_clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .act_detect(act_detect), .inact_detect(inact_detect),
    .inactivity_threshold(th), .inactivity_time(tm),
    .power_mode(power_mode), .sensing_en(sensing_en),
    .sample_tick(sample_tick), .conv_tick(conv_tick),
    .low_power_active(low_power_active), .odr_code(odr_code),
    .fifo_hold(fifo_hold));

  // whole run needs about a thousand cycles; a hang stops well after
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask

  // mode moves only on a grid tick, so allow two grid steps
  task automatic wait_mode(input logic [1:0] m);
    for (int k = 0; k < 2 * BASE + 4 && power_mode !== m; k++)
      @(negedge core_clk);
    chk(power_mode, m);
  endtask

  // cycles between two sample strobes
  task automatic period(output logic [15:0] q);
    for (int k = 0; k < 5000 && sample_tick !== 1'b1; k++)
      @(negedge core_clk);
    @(negedge core_clk);
    q = 1;
    while (sample_tick !== 1'b1 && q < 5000) begin
      @(negedge core_clk);
      q++;
    end
  endtask

  // counts samples, conversions and cycles where the two disagree
  task automatic count_ticks(input int len, output logic [15:0] s,
      output logic [15:0] c, output logic [15:0] d);
    s = 0;
    c = 0;
    d = 0;
    repeat (len) begin
      @(negedge core_clk);
      s += (sample_tick === 1'b1);
      c += (conv_tick === 1'b1);
      d += (conv_tick !== sample_tick);
    end
  endtask

  task automatic pulse(input logic act);
    @(negedge core_clk);
    if (act) act_detect = 1'b1;
    else inact_detect = 1'b1;
    @(negedge core_clk);
    act_detect = 1'b0;
    inact_detect = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    nrst = 1'b0;
    act_detect = 1'b0;
    inact_detect = 1'b0;
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(power_mode, acpm_pkg::ACPM_STANDBY);
    chk(sensing_en, 1'b0);
    chk(fifo_hold, 1'b1);
    for (int i = 0; i < 4; i++) rd_chk(adr[i], rst[i]);
    // configure everything while still in standby
    for (int i = 0; i < 4; i++) host.wr(adr[i], val[i]);
    host.wr(8'h30, 8'h77);
    for (int i = 0; i < 4; i++) rd_chk(adr[i], val[i]);
    rd_chk(8'h30, 8'h00);
    chk({th, tm}, 16'h5AA5);
    count_ticks(200, ns, nc, nd);
    chk(ns, 0);
    chk(power_mode, acpm_pkg::ACPM_STANDBY);
    host.wr(acpm_pkg::ADDR_POWER, 8'h08);
    wait_mode(acpm_pkg::ACPM_MEASURE);
    chk(sensing_en, 1'b1);
    chk(fifo_hold, 1'b0);
    rd_chk(8'h25, 8'h5A);
    // top four codes: each step down doubles the sample spacing
    for (int c = 15; c >= 12; c--) begin
      host.set_rate(c[3:0], 1'b0);
      period(p);
      period(p);
      chk(p, 16'(BASE << (15 - c)));
      chk(odr_code, c[3:0]);
    end
    host.set_rate(4'hC, 1'b1);
    repeat (BASE + 2) @(negedge core_clk);
    chk(low_power_active, 1'b1);
    count_ticks(64, ns, nc, nd);
    chk(nd, 0);
    host.set_rate(4'hC, 1'b0);
    repeat (BASE + 2) @(negedge core_clk);
    chk(low_power_active, 1'b0);
    count_ticks(64, ns, nc, nd);
    chk(nc, 16'(64 / BASE));
    // inactivity without autosleep armed must not put the part to sleep
    pulse(1'b0);
    repeat (2 * BASE + 4) @(negedge core_clk);
    chk(power_mode, acpm_pkg::ACPM_MEASURE);
    host.set_rate(4'hF, 1'b0);
    host.arm_autosleep(8'h10, 8'h20);
    pulse(1'b0);
    wait_mode(acpm_pkg::ACPM_SLEEP);
    chk({th, tm}, 16'h1020);
    chk(odr_code, acpm_pkg::RATE_CODE_SLEEP);
    chk(sensing_en, 1'b1);
    pulse(1'b1);
    wait_mode(acpm_pkg::ACPM_MEASURE);
    chk(odr_code, 4'hF);
    // dropping autosleep and link while asleep wakes the part up
    pulse(1'b0);
    wait_mode(acpm_pkg::ACPM_SLEEP);
    host.wr(acpm_pkg::ADDR_POWER, 8'h08);
    wait_mode(acpm_pkg::ACPM_MEASURE);
    host.wr(acpm_pkg::ADDR_POWER, 8'h00);
    wait_mode(acpm_pkg::ACPM_STANDBY);
    chk(fifo_hold, 1'b1);
    chk(sensing_en, 1'b0);
    rd_chk(8'h26, 8'h20);
    rd_chk(8'h2C, 8'h0F);
    // clearing measure while asleep goes straight to standby
    host.wr(acpm_pkg::ADDR_POWER, 8'h38);
    wait_mode(acpm_pkg::ACPM_MEASURE);
    pulse(1'b0);
    wait_mode(acpm_pkg::ACPM_SLEEP);
    host.wr(acpm_pkg::ADDR_POWER, 8'h00);
    wait_mode(acpm_pkg::ACPM_STANDBY);
    // reset in mid-run from measurement: mode and registers to defaults
    host.wr(acpm_pkg::ADDR_POWER, 8'h08);
    wait_mode(acpm_pkg::ACPM_MEASURE);
    nrst = 1'b0;
    @(negedge core_clk);
    chk(power_mode, acpm_pkg::ACPM_STANDBY);
    chk(fifo_hold, 1'b1);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 4; i++) rd_chk(adr[i], rst[i]);
    chk({th, tm}, 16'h0000);
    chk(sensing_en, 1'b0);
    test_done();
  end
endmodule
